// >>> core/timer_glue_pkg.sv
// Notes on behaviour
// - Capture input picks source a, b, core read trigger, any read trigger.
// - Select bit 13 routes tb2 core direction from source a or b.
// - Select bit 12 routes tb2 core count from source a or b.
// - Select bit 11 routes tb2 aux direction from source a or b.
// - Select bit 10 routes tb2 aux count from source a or b.
// - Bits 9:8 route tb1 aux b direction from sources a to d.
// - Bits 7:6 route tb1 aux b count from sources a to d.
// - Bits 5:4 route tb1 core direction from sources a to d.
// - Bits 3:2 route tb1 core count from sources a to d.
// - Select bit 1 routes tb1 aux a direction from source a or b.
// - Select bit 0 routes tb1 aux a count from source a or b.
// - Select register resets to zero, every input on source a.
// - Identification register is read only: kind 15:8, revision 7:0.
// - Whole block runs on the system clock, no own module clock.
// - Six interrupt outputs: five timers plus capture reload unit.
// - Register reads stay valid while the module is disabled.
// - While disabled only select and tb2 aux control accept writes.
// - tb2 core wrap pulse goes to capture unit, supervisor and pin.
// - Internal read trigger capture needs the rising edge selection.
package timer_glue_pkg;

  localparam int          ADDR_W       = 12;
  localparam int          NUM_ROUTED   = 11;
  localparam int          NUM_TIMERS   = 5;
  localparam logic [11:0] OFF_SEL      = 12'h000;
  localparam logic [11:0] OFF_ID       = 12'h004;
  localparam logic [11:0] OFF_AUX      = 12'h008;
  localparam logic [11:0] OFF_STATUS   = 12'h00C;
  localparam logic [11:0] OFF_WRAP     = 12'h010;
  localparam logic [15:0] SEL_RESET    = 16'h0000;
  localparam logic [15:0] AUX_RESET    = 16'h0000;
  localparam int          CAP_EDGE_LSB = 12;
  localparam logic [1:0]  EDGE_OFF     = 2'h0;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam int          WRAP_PIN_BIT = 0;
  localparam int          CAP_IDX      = 10;

  // Index 10 capture, 9..0 as the select fields from high to low
  typedef struct packed {
    logic [NUM_ROUTED-1:0][3:0] cand;
  } src_t;

  typedef struct packed {
    logic [NUM_ROUTED-1:0] sig;
  } routed_t;

endpackage : timer_glue_pkg

// >>> core/timer_input_select_and_id.sv
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module timer_input_select_and_id #(
  parameter logic [7:0] KIND_CODE = 8'hA5, // Arbitrary value
  parameter logic [7:0] REV_CODE  = 8'h03  // Arbitrary value
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [timer_glue_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  input  wire logic                        module_disabled,
  input  wire timer_glue_pkg::src_t        src,
  output      timer_glue_pkg::routed_t     routed,
  output      logic [15:0]                 tb2_aux_control,
  output      logic [1:0]                  capture_edge_eff,
  input  wire logic [4:0]                  timer_irq_req,
  input  wire logic                        capture_reload_irq_req,
  output      logic [4:0]                  timer_irq,
  output      logic                        capture_reload_irq,
  input  wire logic                        tb2_core_wrap_pulse,
  output      logic                        wrap_to_capture,
  output      logic                        wrap_to_supervisor,
  output      logic                        wrap_to_pin
);
  import timer_glue_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (KIND_CODE == 8'h00) begin : g_bad_kind
    $error("Module kind code must not be zero");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] sel_q;
  logic [15:0] aux_q;
  logic        wrap_en_q;
  routed_t     routed_q;
  logic [1:0]  edge_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [4:0]  tirq_q;
  logic        capture_reload_irq_q;
  logic        wrap_cap_q;
  logic        wrap_sup_q;
  logic        wrap_pin_q;

  logic        setup;
  logic        access_done;
  logic        hit_sel;
  logic        hit_id;
  logic        hit_aux;
  logic        hit_status;
  logic        hit_wrap;
  logic        mapped;
  logic        wr_allowed;
  logic        wr_ok;
  logic        internal_cap;
  logic [31:0] rd_data;
  logic [1:0]  edge_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign setup       = psel & ~penable & ~pready_q;
  assign access_done = psel & penable & pready_q;

  always_comb begin
    hit_sel    = (paddr == OFF_SEL);
    hit_id     = (paddr == OFF_ID);
    hit_aux    = (paddr == OFF_AUX);
    hit_status = (paddr == OFF_STATUS);
    hit_wrap   = (paddr == OFF_WRAP);
    mapped     = hit_sel | hit_id | hit_aux | hit_status | hit_wrap;
    // Disabled module keeps only two write targets open
    wr_allowed = hit_sel | hit_aux |
                 (hit_wrap & ~module_disabled);
    wr_ok      = pwrite & wr_allowed;
  end

  // Reads never look at the disable input
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_sel) begin
      rd_data[15:0] = sel_q;
    end
    if (hit_id) begin
      rd_data[15:0] = {KIND_CODE, REV_CODE};
    end
    if (hit_aux) begin
      rd_data[15:0] = aux_q;
    end
    if (hit_status) begin
      rd_data[NUM_ROUTED-1:0] = routed_q.sig;
    end
    if (hit_wrap) begin
      rd_data[WRAP_PIN_BIT] = wrap_en_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait-free access cycle after setup
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr_q <= ~mapped | (pwrite & ~wr_allowed);
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q <= SEL_RESET;
    end else if (access_done & wr_ok & hit_sel) begin
      sel_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_q <= AUX_RESET;
    end else if (access_done & wr_ok & hit_aux) begin
      aux_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_en_q <= 1'b0;
    end else if (access_done & wr_ok & hit_wrap) begin
      wrap_en_q <= pwdata[WRAP_PIN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Input routing
  // ----------------------------------------------------------------
  // Outputs are registered, so a new select shows one cycle later
  for (genvar i = 0; i < NUM_ROUTED; i++) begin : g_route
    // Fields: 1-bit at 1:0, 2-bit from 3:2 up to 9:8, then 1-bit, 15:14
    localparam int LSB = (i <= 1) ? i : (i <= 5) ? 2 * i - 2 : i + 4;
    localparam int WID = (i >= 2 && i <= 5) || (i == CAP_IDX) ? 2 : 1;
    logic [1:0] way;
    if (WID == 2) begin : g_four
      assign way = sel_q[LSB +: 2];
    end else begin : g_two
      assign way = {1'b0, sel_q[LSB]};
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        routed_q.sig[i] <= 1'b0;
      end else begin
        routed_q.sig[i] <= src.cand[i][way];
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture edge guard
  // ----------------------------------------------------------------
  // Internal read triggers are short strobes; only rising edges mean
  // a read, so any enabled edge choice is narrowed to rising.
  assign internal_cap = sel_q[15];

  always_comb begin
    edge_d = aux_q[CAP_EDGE_LSB +: 2];
    if (internal_cap && edge_d != EDGE_OFF) begin
      edge_d = EDGE_RISE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_q <= EDGE_OFF;
    end else begin
      edge_q <= edge_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt lines and wrap export
  // ----------------------------------------------------------------
  // Single pclk domain: timers tick from the system clock itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tirq_q  <= 5'h00;
      capture_reload_irq_q <= 1'b0;
    end else begin
      tirq_q  <= timer_irq_req;
      capture_reload_irq_q <= capture_reload_irq_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_cap_q <= 1'b0;
      wrap_sup_q <= 1'b0;
      wrap_pin_q <= 1'b0;
    end else begin
      wrap_cap_q <= tb2_core_wrap_pulse;
      wrap_sup_q <= tb2_core_wrap_pulse;
      wrap_pin_q <= tb2_core_wrap_pulse & wrap_en_q;
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign routed             = routed_q;
  assign tb2_aux_control    = aux_q;
  assign capture_edge_eff   = edge_q;
  assign timer_irq          = tirq_q;
  assign capture_reload_irq = capture_reload_irq_q;
  assign wrap_to_capture    = wrap_cap_q;
  assign wrap_to_supervisor = wrap_sup_q;
  assign wrap_to_pin        = wrap_pin_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Flops still sit in reset at the release edge, so skip the edge after
  capture_route_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[10] == $past(src.cand[10][sel_q[15:14]]))
    else $error("Capture input not routed by select");

  tb2_core_dir_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[9] == $past(src.cand[9][sel_q[13]]))
    else $error("tb2 core direction misrouted");

  tb2_core_count_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[8] == $past(src.cand[8][sel_q[12]]))
    else $error("tb2 core count misrouted");

  tb2_aux_dir_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[7] == $past(src.cand[7][sel_q[11]]))
    else $error("tb2 aux direction misrouted");

  tb2_aux_count_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[6] == $past(src.cand[6][sel_q[10]]))
    else $error("tb2 aux count misrouted");

  tb1_aux_b_dir_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[5] == $past(src.cand[5][sel_q[9:8]]))
    else $error("tb1 aux b direction misrouted");

  tb1_aux_b_count_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[4] == $past(src.cand[4][sel_q[7:6]]))
    else $error("tb1 aux b count misrouted");

  tb1_core_dir_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[3] == $past(src.cand[3][sel_q[5:4]]))
    else $error("tb1 core direction misrouted");

  tb1_core_count_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[2] == $past(src.cand[2][sel_q[3:2]]))
    else $error("tb1 core count misrouted");

  tb1_aux_a_dir_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[1] == $past(src.cand[1][sel_q[1]]))
    else $error("tb1 aux a direction misrouted");

  tb1_aux_a_count_a: assert property (
    ##1 $past(presetn) |->
      routed_q.sig[0] == $past(src.cand[0][sel_q[0]]))
    else $error("tb1 aux a count misrouted");

  id_read_a: assert property (
    setup && !pwrite && hit_id |=>
      prdata_q == {16'h0000, KIND_CODE, REV_CODE} && !pslverr_q)
    else $error("Identification read wrong");

  sel_read_a: assert property (
    setup && !pwrite && hit_sel |=> prdata_q == {16'h0000, sel_q})
    else $error("Select read wrong");

  disabled_write_a: assert property (
    access_done && pwrite && hit_wrap && module_disabled |->
      pslverr_q ##1 $stable(wrap_en_q))
    else $error("Write accepted while disabled");

  sel_write_a: assert property (
    access_done && pwrite && hit_sel |=> sel_q == $past(pwdata[15:0]))
    else $error("Select write lost");

  wrap_export_a: assert property (
    tb2_core_wrap_pulse |=> wrap_to_capture && wrap_to_supervisor)
    else $error("Wrap pulse not exported");

  irq_pass_a: assert property (
    $past(presetn) |-> timer_irq == $past(timer_irq_req))
    else $error("Timer interrupt not passed");

  capture_reload_irq_pass_a: assert property (
    $past(presetn) |-> capture_reload_irq == $past(capture_reload_irq_req))
    else $error("Capture reload interrupt not passed");

  wrap_pin_a: assert property (
    $past(presetn) |-> wrap_to_pin == $past(tb2_core_wrap_pulse && wrap_en_q))
    else $error("Wrap pin export wrong");

  unmapped_err_a: assert property (
    setup && !mapped |=> pready_q && pslverr_q && prdata_q == 32'h0000_0000)
    else $error("Unmapped access not refused");

  id_write_err_a: assert property (
    setup && pwrite && hit_id |=> pslverr_q)
    else $error("Identification write not refused");

  aux_write_a: assert property (
    access_done && pwrite && hit_aux |=> aux_q == $past(pwdata[15:0]))
    else $error("Aux control write lost");

  status_read_a: assert property (
    setup && !pwrite && hit_status |=>
      prdata_q == {21'h0, $past(routed_q.sig)})
    else $error("Status read wrong");

  edge_plain_a: assert property (
    ##1 $past(presetn) && !$past(sel_q[15]) |->
      capture_edge_eff == $past(aux_q[CAP_EDGE_LSB +: 2]))
    else $error("Capture edge not taken from control");

  bus_idle_a: assert property (
    !psel |=> !pready_q)
    else $error("Bus answer without request");

  edge_force_a: assert property (
    ##1 $past(sel_q[15]) && $past(aux_q[13:12]) != EDGE_OFF |->
      capture_edge_eff == EDGE_RISE)
    else $error("Internal capture edge not rising");

  bus_answer_a: assert property (
    setup |=> pready_q ##1 !pready_q)
    else $error("Bus answer not one cycle");

  read_cover_c:  cover property (access_done && !pwrite && hit_status);
  write_cover_c: cover property (access_done && pwrite && hit_sel);
  deny_cover_c:  cover property (
    access_done && pwrite && hit_wrap && module_disabled);
  edge_cover_c:  cover property (internal_cap && edge_d == EDGE_RISE);
  pin_cover_c:   cover property (wrap_to_pin);

endmodule : timer_input_select_and_id

// >>> verif/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
  input  wire logic                 pclk,
  input  wire timer_glue_pkg::src_t pat,
  input  wire logic [5:0]           irq_cmd,
  input  wire logic                 wrap_cmd,
  input  wire logic                 wrap_pin,
  output      timer_glue_pkg::src_t src,
  output      logic [4:0]           timer_irq_req,
  output      logic                 capture_reload_irq_req,
  output      logic                 tb2_core_wrap_pulse,
  output      logic                 pin_level
);
  import timer_glue_pkg::*;
  // Pins already in input mode; levels move just after the edge
  always_ff @(posedge pclk) begin
    src <= pat;
  end
  // Pin in output mode with the timer function chosen
  always_ff @(posedge pclk) begin
    pin_level <= wrap_pin;
  end
  // Interrupt nodes assumed enabled, so requests pass straight on
  always_ff @(posedge pclk) begin
    {capture_reload_irq_req, timer_irq_req} <= irq_cmd;
    tb2_core_wrap_pulse <= wrap_cmd;
  end
endmodule : far_side_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
`define CHK(n, x, g) begin tests_run++; if ((g) !== (x)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, x, g); end end
module testbench;
  import timer_glue_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, module_disabled, pready;
  logic pslverr, wrap_cmd, capture_reload_irq;
  logic wrap_to_capture, wrap_to_supervisor, wrap_to_pin, pin_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] tb2_aux_control;
  logic [1:0]  capture_edge_eff;
  logic [4:0]  timer_irq, timer_irq_req;
  logic [5:0]  irq_cmd;
  logic        cr_req, wrap_pulse, e;
  src_t        pat, src;
  routed_t     routed;
  int          err_total, tests_run, cycles;

  timer_input_select_and_id u_timer_input_select_and_id (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .module_disabled(module_disabled), .src(src),
    .routed(routed), .tb2_aux_control(tb2_aux_control),
    .capture_edge_eff(capture_edge_eff), .timer_irq_req(timer_irq_req),
    .capture_reload_irq_req(cr_req), .timer_irq(timer_irq),
    .capture_reload_irq(capture_reload_irq),
    .tb2_core_wrap_pulse(wrap_pulse), .wrap_to_capture(wrap_to_capture),
    .wrap_to_supervisor(wrap_to_supervisor), .wrap_to_pin(wrap_to_pin));
  far_side_model u_far_side_model (.pclk(pclk), .pat(pat),
    .irq_cmd(irq_cmd), .wrap_cmd(wrap_cmd), .src(src),
    .timer_irq_req(timer_irq_req), .capture_reload_irq_req(cr_req),
    .tb2_core_wrap_pulse(wrap_pulse), .wrap_pin(wrap_to_pin),
    .pin_level(pin_level));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task print_verdict;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One APB transfer; waits for pready, timeout cuts a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Candidate selected by code c is 1, all others 0 (one-bit fields: c[0])
  function automatic src_t pat_for(input logic [1:0] c);
    src_t p;
    for (int i = 0; i < NUM_ROUTED; i++) begin
      p.cand[i] = (i inside {0, 1, 6, 7, 8, 9}) ? 4'h1 << c[0] : 4'h1 << c;
    end
    return p;
  endfunction : pat_for

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    tick(2);
    `CHK("routed rst", 11'h7FF, routed.sig)
    apb(1'b0, OFF_SEL, 32'h0);
    `CHK("sel rst", 32'h0, r)
  endtask : t_reset

  task t_route;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      apb(1'b1, OFF_SEL, {16'h0, c, {4{c[0]}}, {4{c}}, {2{c[0]}}});
      pat <= pat_for(c);
      tick(3);
      `CHK("hit hi", 4'hF, routed.sig[10:7])
      `CHK("hit mid", 4'hF, routed.sig[6:3])
      `CHK("hit lo", 3'h7, routed.sig[2:0])
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK("status", 32'h7FF, r)
      pat <= ~pat_for(c);
      tick(3);
      `CHK("miss hi", 4'h0, routed.sig[10:7])
      `CHK("miss mid", 4'h0, routed.sig[6:3])
      `CHK("miss lo", 3'h0, routed.sig[2:0])
    end
  endtask : t_route

  task t_regs;
    apb(1'b0, OFF_ID, 32'h0);
    `CHK("id", 32'h0000A503, r)
    apb(1'b1, OFF_ID, 32'h0);
    `CHK("id wr err", 1'b1, e)
    apb(1'b1, OFF_SEL, 32'hFFFFFFFF);
    apb(1'b0, OFF_SEL, 32'h0);
    `CHK("sel resv", 32'h0000FFFF, r)
    apb(1'b0, 12'h014, 32'h0);
    `CHK("unmapped", 1'b1, e)
  endtask : t_regs

  task t_capture_edge;
    apb(1'b1, OFF_AUX, 32'h00002000);
    tick(2);
    `CHK("edge forced", 2'h1, capture_edge_eff)
    apb(1'b1, OFF_SEL, 32'h0);
    tick(2);
    `CHK("edge kept", 2'h2, capture_edge_eff)
    `CHK("aux out", 16'h2000, tb2_aux_control)
  endtask : t_capture_edge

  task t_irq_wrap;
    apb(1'b1, OFF_WRAP, 32'h1);
    irq_cmd <= 6'h2A;
    wrap_cmd <= 1'b1;
    tick(3);
    `CHK("irq", 6'h2A, {capture_reload_irq, timer_irq})
    `CHK("wrap cap", 1'b1, wrap_to_capture)
    `CHK("wrap sup", 1'b1, wrap_to_supervisor)
    `CHK("wrap pin", 1'b1, wrap_to_pin)
    irq_cmd <= 6'h15;
    tick(1);
    `CHK("pin level", 1'b1, pin_level)
    tick(2);
    `CHK("irq alt", 6'h15, {capture_reload_irq, timer_irq})
    irq_cmd <= 6'h0;
    wrap_cmd <= 1'b0;
  endtask : t_irq_wrap

  task t_disabled;
    module_disabled <= 1'b1;
    apb(1'b0, OFF_ID, 32'h0);
    `CHK("id dis", 32'h0000A503, r)
    apb(1'b1, OFF_SEL, 32'h3);
    `CHK("sel dis err", 1'b0, e)
    apb(1'b1, OFF_AUX, 32'h0041);
    `CHK("aux dis err", 1'b0, e)
    apb(1'b0, OFF_AUX, 32'h0);
    `CHK("aux dis", 32'h41, r)
    apb(1'b1, OFF_WRAP, 32'h0);
    `CHK("wrap dis err", 1'b1, e)
    apb(1'b0, OFF_WRAP, 32'h0);
    `CHK("wrap kept", 32'h1, r)
    apb(1'b0, OFF_SEL, 32'h0);
    `CHK("sel dis", 32'h3, r)
  endtask : t_disabled

  // ----------------------------------------------------------------
  // Clock, timeout, main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, module_disabled, wrap_cmd} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    irq_cmd = 6'h0;
    pat = pat_for(2'h0);
    tick(8);
    presetn <= 1'b1;
    t_reset();
    t_route();
    t_regs();
    t_capture_edge();
    t_irq_wrap();
    t_disabled();
    print_verdict();
  end
endmodule : testbench
